// File: design/io_timer_channel_defs.vh
// Register map, field positions, reset values and mode codes of the timer
`ifndef IO_TIMER_CHANNEL_DEFS_VH
`define IO_TIMER_CHANNEL_DEFS_VH

`define ITC_ADDR_W       8
`define ITC_DATA_W       16

`define ITC_OFF_CTRL     8'h00
`define ITC_OFF_COUNT    8'h04
`define ITC_OFF_RELOAD0  8'h08
`define ITC_OFF_RELOAD1  8'h0c
`define ITC_OFF_MEASURE  8'h10
`define ITC_OFF_STATUS   8'h14

`define ITC_CTRL_EN      0
`define ITC_CTRL_MODE_LO 1
`define ITC_CTRL_MODE_HI 3
`define ITC_CTRL_EEN     4
`define ITC_CTRL_EDGE_LO 5
`define ITC_CTRL_EDGE_HI 6
`define ITC_CTRL_LVL     7
`define ITC_CTRL_CKS_LO  8
`define ITC_CTRL_CKS_HI  9

`define ITC_STAT_EN      0
`define ITC_STAT_FF      1
`define ITC_STAT_RUN     2
`define ITC_STAT_PHASE   3

`define ITC_RST_CTRL     10'h000
`define ITC_RST_COUNT    16'h0000
`define ITC_RST_RELOAD   16'h0000
`define ITC_RST_MEASURE  16'h0000
`define ITC_ALL_ONES     16'hffff

`define ITC_MODE_SINGLE  3'h0
`define ITC_MODE_DELAYED 3'h1
`define ITC_MODE_CONT    3'h2
`define ITC_MODE_PWM     3'h3
`define ITC_MODE_MCLEAR  3'h4
`define ITC_MODE_MFREE   3'h5
`define ITC_MODE_NOISE_H 2'h3

`define ITC_EDGE_RISE    2'h0
`define ITC_EDGE_FALL    2'h1
`define ITC_EDGE_BOTH    2'h2
`define ITC_EDGE_LEVEL   2'h3

`endif

// File: design/io_timer_channel.v
// One channel of the input/output 16-bit timer with register port
//
// Operation
// - 16-bit counter, reload and measure registers
// - Start by software bit or qualified input
// - Exactly one software-selected mode at once
// - Measure modes count down, capture copies counter
// - Measure clear capture reloads all ones when the input enable bit is set
// - Measure free-run wraps to all ones
// - Measure interrupts on underflow, capture; software stop
// - Noise: valid level counts, underflow interrupts, stops
// - Noise: invalid level pauses, valid reloads, restarts
// - Noise stops on underflow or enable clear
// - PWM loads reload0, then alternates reload1/reload0
// - PWM toggles at start, underflow; stop immediately
// - PWM interrupt on even underflows, DMA every
// - Only DMA-capable channel requests DMA
// - Single-shot loads reload0, stops at first underflow
// - Delayed single-shot reloads once, stops second
// - Delayed toggles and requests at both underflows
// - Continuous reloads reload0 every underflow, toggles
// - Start and start toggle wait for count clock
// - Mode field encodes seven modes, 11x noise
// - External input enable bit gates input start
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "io_timer_channel_defs.vh"

module io_timer_channel #(
	parameter DMA_CAPABLE = 1'b0
) (
	input  wire                     clk,
	input  wire                     rst,
	input  wire [`ITC_ADDR_W-1:0]   reg_addr,
	input  wire [`ITC_DATA_W-1:0]   reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output reg  [`ITC_DATA_W-1:0]   reg_rdata,
	input  wire [3:0]               clock_bus,
	input  wire                     ext_in,
	input  wire                     capture_in,
	output reg                      out_ff,
	output reg                      irq_underflow,
	output reg                      irq_capture,
	output reg                      dma_req
);

////////////////////////////////////////////////////////////////////////////////

localparam [3:0] S_IDLE  = 4'b0001;
localparam [3:0] S_ARM   = 4'b0010;
localparam [3:0] S_RUN   = 4'b0100;
localparam [3:0] S_PAUSE = 4'b1000;

// Edge or level qualifier shared by the start input and the capture input
function qualify;
	input       cur;
	input       prev;
	input [1:0] sel;
	input       high;
	begin
		case (sel)
		`ITC_EDGE_RISE: qualify = cur & ~prev;
		`ITC_EDGE_FALL: qualify = ~cur & prev;
		`ITC_EDGE_BOTH: qualify = cur ^ prev;
		default:        qualify = high ? cur : ~cur;
		endcase
	end
endfunction

reg  [3:0]             state;
reg                    enable;
reg  [2:0]             mode;
reg                    ext_en;
reg  [1:0]             edge_sel;
reg                    level_high;
reg  [1:0]             clk_sel;
reg  [`ITC_DATA_W-1:0] count;
reg  [`ITC_DATA_W-1:0] reload0;
reg  [`ITC_DATA_W-1:0] reload1;
reg  [`ITC_DATA_W-1:0] measure;
reg                    phase;
reg                    ext_prev;
reg                    cap_prev;

wire wr_ctrl  = reg_wr && (reg_addr == `ITC_OFF_CTRL);
wire tick     = clock_bus[clk_sel];
wire is_noise = (mode[2:1] == `ITC_MODE_NOISE_H);
wire is_meas  = (mode == `ITC_MODE_MCLEAR) || (mode == `ITC_MODE_MFREE);
wire lvl_ok   = level_high ? ext_in : ~ext_in;
wire [1:0] cap_sel = (edge_sel == `ITC_EDGE_LEVEL) ? `ITC_EDGE_RISE
	: edge_sel;

// Noise mode is started by level inside the run logic, not here
wire ext_go = ext_en && !is_noise && (state == S_IDLE)
	&& qualify(ext_in, ext_prev, edge_sel, level_high);
wire cap_ev = is_meas && (state == S_RUN)
	&& qualify(capture_in, cap_prev, cap_sel, 1'b1);
wire uflow  = (state == S_RUN) && enable && tick
	&& (count == {`ITC_DATA_W{1'b0}})
	&& !(is_noise && !lvl_ok);
wire uf_stop = uflow && (is_noise || (mode == `ITC_MODE_SINGLE)
	|| ((mode == `ITC_MODE_DELAYED) && phase));

////////////////////////////////////////////////////////////////////////////////
// Control fields and the enable bit

always @(posedge clk) begin
	if (rst) begin
		enable     <= 1'b0;
		mode       <= `ITC_MODE_SINGLE;
		ext_en     <= 1'b0;
		edge_sel   <= 2'h0;
		level_high <= 1'b0;
		clk_sel    <= 2'h0;
		ext_prev   <= 1'b0;
		cap_prev   <= 1'b0;
	end else begin
		ext_prev <= ext_in;
		cap_prev <= capture_in;
		// Underflow stop beats an input start; a software write beats both
		if (ext_go)
			enable <= 1'b1;
		if (uf_stop)
			enable <= 1'b0;
		if (wr_ctrl) begin
			enable     <= reg_wdata[`ITC_CTRL_EN];
			mode       <= reg_wdata[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO];
			ext_en     <= reg_wdata[`ITC_CTRL_EEN];
			edge_sel   <= reg_wdata[`ITC_CTRL_EDGE_HI:`ITC_CTRL_EDGE_LO];
			level_high <= reg_wdata[`ITC_CTRL_LVL];
			clk_sel    <= reg_wdata[`ITC_CTRL_CKS_HI:`ITC_CTRL_CKS_LO];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Counter, reload registers, output flip-flop and event pulses

always @(posedge clk) begin
	if (rst) begin
		state         <= S_IDLE;
		count         <= `ITC_RST_COUNT;
		reload0       <= `ITC_RST_RELOAD;
		reload1       <= `ITC_RST_RELOAD;
		measure       <= `ITC_RST_MEASURE;
		phase         <= 1'b0;
		out_ff        <= 1'b0;
		irq_underflow <= 1'b0;
		irq_capture   <= 1'b0;
		dma_req       <= 1'b0;
	end else begin
		irq_underflow <= 1'b0;
		irq_capture   <= 1'b0;
		dma_req       <= 1'b0;
		if (reg_wr && (reg_addr == `ITC_OFF_RELOAD0))
			reload0 <= reg_wdata;
		if (reg_wr && (reg_addr == `ITC_OFF_RELOAD1))
			reload1 <= reg_wdata;
		// A preset written while running is overridden by a same-cycle
		// hardware update below
		if (reg_wr && (reg_addr == `ITC_OFF_COUNT))
			count <= reg_wdata;
		case (state)
		S_IDLE: begin
			if (enable)
				state <= S_ARM;
		end
		S_ARM: begin
			// Start waits for the selected count clock
			if (!enable) begin
				state <= S_IDLE;
			end else if (tick) begin
				phase <= 1'b0;
				if (is_noise) begin
					if (lvl_ok) begin
						count <= reload0;
						state <= S_RUN;
					end
				end else begin
					state <= S_RUN;
					case (mode)
					`ITC_MODE_SINGLE, `ITC_MODE_PWM: begin
						count  <= reload0;
						out_ff <= ~out_ff;
					end
					`ITC_MODE_CONT:
						out_ff <= ~out_ff;
					default: ;
					endcase
				end
			end
		end
		S_RUN: begin
			if (!enable) begin
				state <= S_IDLE;
			end else if (is_noise && !lvl_ok) begin
				state <= S_PAUSE;
			end else if (uflow) begin
				irq_underflow <= 1'b1;
				dma_req       <= (DMA_CAPABLE != 0);
				case (mode)
				`ITC_MODE_SINGLE: begin
					out_ff <= ~out_ff;
					state  <= S_IDLE;
				end
				`ITC_MODE_DELAYED: begin
					out_ff <= ~out_ff;
					phase  <= 1'b1;
					if (phase)
						state <= S_IDLE;
					else
						count <= reload0;
				end
				`ITC_MODE_CONT: begin
					out_ff <= ~out_ff;
					count  <= reload0;
				end
				`ITC_MODE_PWM: begin
					out_ff        <= ~out_ff;
					count         <= phase ? reload0 : reload1;
					phase         <= ~phase;
					irq_underflow <= phase;
				end
				`ITC_MODE_MCLEAR, `ITC_MODE_MFREE:
					count <= `ITC_ALL_ONES;
				default:
					state <= S_IDLE;
				endcase
			end else if (tick) begin
				count <= count - 16'h0001;
			end
			// A measure-clear capture reload (input enable set) overrides the decrement of the same cycle
			if (cap_ev && enable) begin
				measure     <= count;
				irq_capture <= 1'b1;
				if ((mode == `ITC_MODE_MCLEAR) && ext_en)
					count <= `ITC_ALL_ONES;
			end
		end
		S_PAUSE: begin
			if (!enable)
				state <= S_IDLE;
			else if (tick && lvl_ok) begin
				count <= reload0;
				state <= S_RUN;
			end
		end
		default:
			state <= S_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port, data in the cycle after the strobe only

always @(posedge clk) begin
	if (rst) begin
		reg_rdata <= {`ITC_DATA_W{1'b0}};
	end else if (reg_rd) begin
		case (reg_addr)
		`ITC_OFF_CTRL:
			reg_rdata <= {6'h00, clk_sel, level_high, edge_sel, ext_en,
				mode, enable};
		`ITC_OFF_COUNT:   reg_rdata <= count;
		`ITC_OFF_RELOAD0: reg_rdata <= reload0;
		`ITC_OFF_RELOAD1: reg_rdata <= reload1;
		`ITC_OFF_MEASURE: reg_rdata <= measure;
		`ITC_OFF_STATUS:
			reg_rdata <= {12'h000, phase, (state == S_RUN), out_ff, enable};
		default:          reg_rdata <= {`ITC_DATA_W{1'b0}};
		endcase
	end else begin
		reg_rdata <= {`ITC_DATA_W{1'b0}};
	end
end

endmodule
`default_nettype wire

// File: tb/ext_source.sv
// Far-side model: external start level line and capture line
`timescale 1ns/1ps
`default_nettype none
module ext_source (
	input  wire logic clk,
	input  wire logic lvl,
	input  wire logic cap,
	output var  logic ext_in,
	output var  logic capture_in
);
	initial ext_in = 1'b0;
	initial capture_in = 1'b0;
	// Lines move just after an edge, as a clocked source would
	always @(posedge clk) begin
		ext_in <= lvl;
		capture_in <= cap;
	end
endmodule
`default_nettype wire

// File: tb/io_timer_channel_props.sv
// Port checker for one timer channel
`timescale 1ns/1ps
`default_nettype none
module io_timer_channel_props #(
	parameter DMA_CAPABLE = 1'b0
) (
	input wire        clk,
	input wire        rst,
	input wire [7:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	input wire [3:0]  clock_bus,
	input wire        capture_in,
	input wire        out_ff,
	input wire        irq_underflow,
	input wire        irq_capture,
	input wire        dma_req
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	logic [3:0] tick_age;
	logic [3:0] cap_age;
	logic       cap_d;
	// Ages saturate so a long quiet spell never wraps into range
	always @(posedge clk) begin
		cap_d <= capture_in;
		if (rst || |clock_bus)
			tick_age <= rst ? 4'hf : 4'h0;
		else if (tick_age != 4'hf)
			tick_age <= tick_age + 4'h1;
		if (rst || capture_in != cap_d)
			cap_age <= rst ? 4'hf : 4'h0;
		else if (cap_age != 4'hf)
			cap_age <= cap_age + 4'h1;
	end
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside its slot");
	chk_ff_on_tick: assert property ($changed(out_ff) |-> tick_age <= 4'h1)
		else $error("output toggled without a count pulse");
	chk_uf_on_tick: assert property (irq_underflow |-> tick_age <= 4'h2)
		else $error("underflow pulse without a count pulse");
	chk_dma_tick: assert property (dma_req |-> tick_age <= 4'h2)
		else $error("transfer request without a count pulse");
	chk_dma_gated: assert property (dma_req |-> DMA_CAPABLE == 1'b1)
		else $error("transfer request from a plain channel");
	chk_cap_cause: assert property (irq_capture |-> cap_age <= 4'h3)
		else $error("capture pulse without an input edge");
	chk_cap_single: assert property (irq_capture |=> !irq_capture)
		else $error("capture pulse longer than one cycle");
	chk_stop_quiet: assert property (reg_wr && reg_addr == 8'h00 &&
		!reg_wdata[0] |=> ##1 $stable(out_ff)[*2])
		else $error("output moved after counting was disabled");
endmodule
bind io_timer_channel io_timer_channel_props #(.DMA_CAPABLE(DMA_CAPABLE))
	props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .clock_bus(clock_bus), .capture_in(capture_in),
	.out_ff(out_ff), .irq_underflow(irq_underflow),
	.irq_capture(irq_capture), .dma_req(dma_req));
`default_nettype wire

// File: tb/test_io_timer_channel.sv
// Self-checking bench for one timer channel
`timescale 1ns/1ps
`default_nettype none
module test_io_timer_channel;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  clock_bus = 4'h0;
	logic        lvl = 1'b0;
	logic        cap = 1'b0;
	wire  [15:0] reg_rdata;
	wire         ext_in, capture_in, out_ff;
	wire         irq_underflow, irq_capture, dma_req;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          hi, nu, nd, nc, gap, last;
	logic [15:0] rv;
	logic [15:0] ec[5] = '{16'h0010, 16'h0030, 16'h0050, 16'h0000, 16'h00f0};
	logic        el[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	int          eh[5] = '{4, 4, 4, 0, -1};
	int          eu[5] = '{1, 1, 1, 0, -2};
	ext_source src (.clk(clk), .lvl(lvl), .cap(cap), .ext_in(ext_in),
		.capture_in(capture_in));
	io_timer_channel #(.DMA_CAPABLE(1'b1)) DUT (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_bus(clock_bus),
		.ext_in(ext_in), .capture_in(capture_in), .out_ff(out_ff),
		.irq_underflow(irq_underflow), .irq_capture(irq_capture),
		.dma_req(dma_req));
	always #12.5 clk = ~clk;
	// A count pulse on bus 0 every cycle, so counts read as cycles
	always @(posedge clk) clock_bus <= {3'h0, ~rst};
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Starts with ctrl, flips the far-side lines at cycle ev, then counts
	task automatic run(input logic [15:0] c, input logic l,
		input int n, ev, ehi, eu1, ed, eg);
		hi = 0;
		nu = 0;
		nd = 0;
		nc = 0;
		last = 0;
		lvl <= l;
		cap <= 1'b0;
		repeat (3) @(posedge clk);
		wr(8'h00, c);
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			if (i == ev) begin
				lvl <= ~lvl;
				cap <= 1'b1;
			end
			#1 hi += (out_ff === 1'b1);
			nd += (dma_req === 1'b1);
			nc += (irq_capture === 1'b1);
			if (irq_underflow === 1'b1) begin
				gap = i - last;
				last = i;
				nu++;
			end
		end
		wr(8'h00, 16'h0000);
		if (ehi >= 0) check(hi, ehi);
		if (eu1 == -2) check(nu != 0, 1);
		else if (eu1 >= 0) check(nu, eu1);
		if (ed >= 0) check(nd, ed);
		if (eg > 0) check(gap, eg);
	endtask
	task automatic close_out;
		$display("Mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a <= 24; a += 4) begin
			rd(a[7:0]);
			check(rv, 16'h0000);
		end
		wr(8'h10, 16'h1234);
		rd(8'h10);
		check(rv, 16'h0000);
		wr(8'h08, 16'hffff);
		rd(8'h08);
		check(rv, 16'hffff);
		wr(8'h08, 16'h0003);
		run(16'h0001, 1'b0, 20, 0, 4, 1, 1, 0);
		rd(8'h14);
		check(rv[0], 1'b0);
		wr(8'h04, 16'h0002);
		run(16'h0003, 1'b0, 20, 0, 4, 2, 2, 4);
		wr(8'h0c, 16'h0004);
		// Window ends before the next underflow so the output is left low
		run(16'h0007, 1'b0, 35, 0, 16, 3, 7, 9);
		rd(8'h04);
		gap = rv;
		rd(8'h04);
		check(rv, gap[15:0]);
		wr(8'h04, 16'h0001);
		run(16'h0005, 1'b0, 20, 0, -1, -1, -1, 4);
		rd(8'h04);
		gap = rv;
		rd(8'h04);
		check(rv, gap[15:0]);
		run(16'h0101, 1'b0, 20, 0, 0, 0, 0, 0);
		run(16'h008d, 1'b0, 20, 5, -1, 1, 1, 0);
		run(16'h008d, 1'b1, 20, 2, -1, 0, 0, 0);
		wr(8'h04, 16'h0003);
		run(16'h000b, 1'b0, 12, 0, -1, 1, -1, 0);
		rd(8'h04);
		check(rv > 16'hff00, 1);
		wr(8'h04, 16'h0100);
		run(16'h0019, 1'b0, 12, 5, -1, 0, -1, 0);
		check(nc, 1);
		rd(8'h10);
		check(rv > 16'h00f0 && rv < 16'h0100, 1);
		rd(8'h04);
		check(rv > 16'hff00, 1);
		wr(8'h08, 16'h0003);
		foreach (ec[k]) run(ec[k], el[k], 20, 5, eh[k], eu[k], -1, 0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
